// ---- hw/bpde_defines.vh ----
// Constants for the breakpoint matching and debug entry block.
// Assumes inclusion by bare name from the design files.
`ifndef BPDE_DEFINES_VH
`define BPDE_DEFINES_VH
// ----------------------------------------
// Breakpoint register set
// ----------------------------------------
`define BPDE_BP_RESET 16'hFFFF
`define BPDE_BP_COUNT 6
`define BPDE_BP_FOUR 3'h4
`define BPDE_BP_FIVE 3'h5
// Register breakpoint field layout
`define BPDE_MOD_MSB 3
`define BPDE_MOD_LSB 0
`define BPDE_IDX_MSB 8
`define BPDE_IDX_LSB 4
// Control word bits
`define BPDE_CTL_DME 0
`define BPDE_CTL_REGISTER_BREAK_SELECT 1
`define BPDE_CTL_RESET 16'h0000
// Link command codes (3-bit)
`define BPDE_CMD_NOP 3'h0
`define BPDE_CMD_WR_BP 3'h1
`define BPDE_CMD_RD_BP 3'h2
`define BPDE_CMD_WR_CTL 3'h3
`define BPDE_CMD_WR_DATA 3'h4
`define BPDE_CMD_WR_MASK 3'h5
`define BPDE_CMD_DEBUG 3'h6
`define BPDE_CMD_RD_CTL 3'h7
// Link word: 10 bits, status in the top two
`define BPDE_WORD_BITS 10
`define BPDE_ST_NONDEBUG 2'h0
`define BPDE_ST_DEBUG_IDLE 2'h1
// Debug entry
`define BPDE_DEBUG_VECTOR 16'h8010
`endif

// ---- hw/bpde_link.v ----
// Serial link receiver/transmitter: shifts 10-bit words on TDI/TDO.
// Assumes tck/tdi/tms already synchronised to ref_clk_i by the parent.
`timescale 1ns/1ps
module bpde_link (
    input wire ref_clk_i,
    input wire rst_n,
    input wire ce_i,
    input wire tck_rise_i,
    input wire tck_fall_i,
    input wire tdi_i,
    input wire tms_i,
    input wire [1:0] status_i,
    input wire [7:0] load_i,
    output reg [9:0] word_o,
    output reg word_valid_o,
    output reg tlr_o,
    output reg tdo_o
);
`include "bpde_defines.vh"
    reg [9:0] shift_in;
    reg [9:0] shift_out;
    reg [3:0] bit_cnt;
    reg [2:0] tms_ones;
    // ----------------------------------------
    // Shifting and Test-Logic-Reset detect
    // ----------------------------------------
    // Five rising TCK edges with TMS high always reach Test-Logic-Reset.
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_in <= 10'h000;
            shift_out <= 10'h000;
            bit_cnt <= 4'h0;
            tms_ones <= 3'h0;
            word_o <= 10'h000;
            word_valid_o <= 1'b0;
            tlr_o <= 1'b0;
            tdo_o <= 1'b0;
        end else if (ce_i) begin
            word_valid_o <= 1'b0;
            tlr_o <= 1'b0;
            if (tck_rise_i) begin
                if (tms_i) begin
                    bit_cnt <= 4'h0;
                    if (tms_ones == 3'h4) begin
                        tlr_o <= 1'b1;
                    end else begin
                        tms_ones <= tms_ones + 3'h1;
                    end
                end else begin
                    tms_ones <= 3'h0;
                    shift_in <= {tdi_i, shift_in[9:1]};
                    if (bit_cnt == 4'h9) begin
                        bit_cnt <= 4'h0;
                        word_o <= {tdi_i, shift_in[9:1]};
                        word_valid_o <= 1'b1;
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
            end
            if (tck_fall_i) begin
                if (bit_cnt == 4'h0) begin
                    shift_out <= {1'b0, status_i, load_i[7:1]};
                    tdo_o <= load_i[0];
                end else begin
                    tdo_o <= shift_out[0];
                    shift_out <= {1'b0, shift_out[9:1]};
                end
            end
        end
    end
endmodule // bpde_link

// ---- hw/bpde_top.v ----
// Breakpoint matching and debug-mode entry engine.
// Assumes a core that reports each executed instruction with its data
// address and destination, and that obeys halt/fetch-block outputs.
`timescale 1ns/1ps
module bpde_top (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire tck_i,
    input wire tms_i,
    input wire tdi_i,
    output wire tdo_o,
    input wire instr_done_i,
    input wire instr_pfx_i,
    input wire dmem_valid_i,
    input wire [15:0] dmem_addr_i,
    input wire dst_valid_i,
    input wire [8:0] dst_reg_i,
    input wire [15:0] dst_data_i,
    input wire [15:0] return_addr_i,
    input wire irq_req_i,
    input wire exit_debug_i,
    output reg fetch_block_o,
    output reg push_o,
    output reg [15:0] push_data_o,
    output reg ip_load_o,
    output reg [15:0] ip_value_o,
    output reg gie_clear_o,
    output reg cpu_halt_o,
    output reg debug_mode_o,
    output wire timer_clk_en_o,
    output wire irq_grant_o
);
`include "bpde_defines.vh"
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    reg [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg tck_d;
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            tck_d <= 1'b0;
        end else if (ce_i) begin
            pin_s1 <= {tck_i, tms_i, tdi_i};
            pin_s2 <= pin_s1;
            tck_d <= pin_s2[2];
        end
    end
    wire tck_rise = pin_s2[2] & ~tck_d;
    wire tck_fall = ~pin_s2[2] & tck_d;
    // ----------------------------------------
    // Link
    // ----------------------------------------
    wire [9:0] word;
    wire word_valid;
    wire tlr;
    reg [7:0] load_byte;
    wire [1:0] status = debug_mode_o ? `BPDE_ST_DEBUG_IDLE : `BPDE_ST_NONDEBUG;
    bpde_link u_link (
        .ref_clk_i(ref_clk_i),
        .rst_n(rst_n),
        .ce_i(ce_i),
        .tck_rise_i(tck_rise),
        .tck_fall_i(tck_fall),
        .tdi_i(pin_s2[0]),
        .tms_i(pin_s2[1]),
        .status_i(status),
        .load_i(load_byte),
        .word_o(word),
        .word_valid_o(word_valid),
        .tlr_o(tlr),
        .tdo_o(tdo_o)
    );
    // ----------------------------------------
    // Command decode and register set
    // ----------------------------------------
    // Word layout: [9:7] command, [6:0] payload. A 16-bit write takes
    // three words: high byte, low byte, then the command with target.
    reg [15:0] bp [0:5];
    reg [15:0] ctl;
    reg [15:0] cmp_value;
    reg [15:0] cmp_mask;
    reg [15:0] stage;
    reg debug_cmd;
    integer i;
    integer j;
    wire [2:0] cmd = word[9:7];
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 6; i = i + 1) begin
                bp[i] <= `BPDE_BP_RESET;
            end
            ctl <= `BPDE_CTL_RESET;
            cmp_value <= 16'h0000;
            cmp_mask <= 16'h0000;
            stage <= 16'h0000;
            load_byte <= 8'h00;
            debug_cmd <= 1'b0;
        end else if (ce_i) begin
            debug_cmd <= 1'b0;
            if (tlr) begin
                for (i = 0; i < 6; i = i + 1) begin
                    bp[i] <= `BPDE_BP_RESET;
                end
                ctl <= `BPDE_CTL_RESET;
            end else if (word_valid) begin
                // Only the link reaches this state; no CPU port exists
                case (cmd)
                    `BPDE_CMD_NOP: begin
                        stage <= {stage[7:0], word[7:0]};
                    end
                    `BPDE_CMD_WR_BP: begin
                        if (word[2:0] < 3'h6) begin
                            bp[word[2:0]] <= stage;
                        end
                    end
                    `BPDE_CMD_RD_BP: begin
                        load_byte <= (word[2:0] < 3'h6) ?
                            (word[3] ? bp[word[2:0]][15:8] : bp[word[2:0]][7:0]) : 8'h00;
                    end
                    `BPDE_CMD_WR_CTL: ctl <= stage;
                    `BPDE_CMD_WR_DATA: cmp_value <= stage;
                    `BPDE_CMD_WR_MASK: cmp_mask <= stage;
                    `BPDE_CMD_DEBUG: debug_cmd <= 1'b1;
                    `BPDE_CMD_RD_CTL: load_byte <= word[3] ? ctl[15:8] : ctl[7:0];
                    default: stage <= stage;
                endcase
            end
        end
    end
    // ----------------------------------------
    // Match logic
    // ----------------------------------------
    wire debug_mode_enable = ctl[`BPDE_CTL_DME];
    wire register_break_select = ctl[`BPDE_CTL_REGISTER_BREAK_SELECT];
    function reg_hit;
        input [15:0] bpv;
        input [8:0] dst;
        begin
            reg_hit = (bpv[`BPDE_MOD_MSB:`BPDE_MOD_LSB] == dst[3:0]) &&
                      (bpv[`BPDE_IDX_MSB:`BPDE_IDX_LSB] == dst[8:4]);
        end
    endfunction
    // Zero mask leaves the data condition true
    wire data_ok = ((dst_data_i ^ cmp_value) & cmp_mask) == 16'h0000;
    reg any_hit;
    always @* begin
        any_hit = 1'b0;
        for (j = 0; j < 4; j = j + 1) begin
            if (dmem_valid_i && dmem_addr_i == bp[j]) begin
                any_hit = 1'b1;
            end
        end
        for (j = 4; j < 6; j = j + 1) begin
            if (register_break_select) begin
                if (dst_valid_i && reg_hit(bp[j], dst_reg_i) && data_ok) begin
                    any_hit = 1'b1;
                end
            end else if (dmem_valid_i && dmem_addr_i == bp[j]) begin
                any_hit = 1'b1;
            end
        end
        any_hit = any_hit & debug_mode_enable & instr_done_i;
    end
    // ----------------------------------------
    // Entry sequence
    // ----------------------------------------
    localparam ST_BG = 3'h0;
    localparam ST_BLOCK = 3'h1;
    localparam ST_PUSH = 3'h2;
    localparam ST_IP = 3'h3;
    localparam ST_GIE = 3'h4;
    localparam ST_DEBUG = 3'h5;
    reg [2:0] state;
    reg [2:0] next_state;
    reg pending;
    reg pfx_hold;
    // A match on a prefix load waits one more instruction
    wire go = pending & instr_done_i & ~instr_pfx_i & ~pfx_hold;
    always @* begin
        next_state = state;
        case (state)
            ST_BG: if (go) next_state = ST_BLOCK;
            ST_BLOCK: next_state = ST_PUSH;
            ST_PUSH: next_state = ST_IP;
            ST_IP: next_state = ST_GIE;
            ST_GIE: next_state = ST_DEBUG;
            ST_DEBUG: if (exit_debug_i) next_state = ST_BG;
            default: next_state = ST_BG;
        endcase
    end
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_BG;
            pending <= 1'b0;
            pfx_hold <= 1'b0;
            fetch_block_o <= 1'b0;
            push_o <= 1'b0;
            push_data_o <= 16'h0000;
            ip_load_o <= 1'b0;
            ip_value_o <= 16'h0000;
            gie_clear_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            debug_mode_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            push_o <= 1'b0;
            ip_load_o <= 1'b0;
            gie_clear_o <= 1'b0;
            if (state == ST_BG) begin
                if (go) begin
                    pending <= 1'b0;
                end else if (any_hit || debug_cmd) begin
                    pending <= 1'b1;
                end
                if (instr_done_i) begin
                    pfx_hold <= instr_pfx_i & (pending | any_hit);
                end
            end else begin
                pending <= 1'b0;
            end
            case (next_state)
                ST_BLOCK: fetch_block_o <= 1'b1;
                ST_PUSH: begin
                    push_o <= 1'b1;
                    push_data_o <= return_addr_i;
                end
                ST_IP: begin
                    ip_load_o <= 1'b1;
                    ip_value_o <= `BPDE_DEBUG_VECTOR;
                end
                ST_GIE: gie_clear_o <= 1'b1;
                ST_DEBUG: begin
                    cpu_halt_o <= 1'b1;
                    debug_mode_o <= 1'b1;
                end
                default: begin
                    fetch_block_o <= 1'b0;
                    cpu_halt_o <= 1'b0;
                    debug_mode_o <= 1'b0;
                end
            endcase
        end
    end
    assign timer_clk_en_o = ~debug_mode_o & ~fetch_block_o;
    assign irq_grant_o = irq_req_i & ~fetch_block_o;
endmodule // bpde_top

// ---- tb/bpde_top_chk.sv ----
// Port assertions for the breakpoint debug entry block.
// Assumes a bind onto bpde_top; all checks share the system clock.
`timescale 1ns/1ps
`include "bpde_defines.vh"
module bpde_top_chk (
    input wire ref_clk_i,
    input wire resetn_i,
    input wire fetch_block_o,
    input wire push_o,
    input wire ip_load_o,
    input wire [15:0] ip_value_o,
    input wire gie_clear_o,
    input wire cpu_halt_o,
    input wire debug_mode_o,
    input wire timer_clk_en_o,
    input wire irq_grant_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_push_after_block: assert property ($rose(fetch_block_o) |=> push_o)
        else $error("no push after fetch block");
    a_ip_after_push: assert property (push_o |=> ip_load_o)
        else $error("no pointer load after push");
    a_gie_after_ip: assert property (ip_load_o |=> gie_clear_o)
        else $error("no enable clear after pointer load");
    a_halt_after_gie: assert property (gie_clear_o |=> cpu_halt_o && debug_mode_o)
        else $error("no halt after enable clear");
    a_debug_vector: assert property (ip_load_o |-> ip_value_o == `BPDE_DEBUG_VECTOR)
        else $error("wrong debug vector");
    a_irq_blocked: assert property (fetch_block_o |-> !irq_grant_o)
        else $error("interrupt granted in debug");
    a_timer_frozen: assert property (debug_mode_o |-> !timer_clk_en_o)
        else $error("timer clock runs in debug");
    a_no_reentry: assert property (debug_mode_o && $past(debug_mode_o) |-> !push_o)
        else $error("second entry while in debug");
endmodule // bpde_top_chk
bind bpde_top bpde_top_chk chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .fetch_block_o(fetch_block_o), .push_o(push_o), .ip_load_o(ip_load_o),
    .ip_value_o(ip_value_o), .gie_clear_o(gie_clear_o), .cpu_halt_o(cpu_halt_o),
    .debug_mode_o(debug_mode_o), .timer_clk_en_o(timer_clk_en_o), .irq_grant_o(irq_grant_o));

// ---- tb/bpde_host.sv ----
// Link host model: shifts 10-bit words out on the serial pins.
// Assumes the device samples the link clock with its own clock.
`timescale 1ns/1ps
module bpde_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire tdo_i
);
    // Link clock rests low between frames, so idle edges never reach the device
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b0;
        tdi_o = 1'b0;
    end
    // Registers are reached only through link words
    task automatic xfer(input logic [9:0] w, output logic [9:0] r);
        for (int i = 0; i < 10; i++) begin
            tdi_o = w[i];
            // Device moves its data line on falls, so each bit is taken before the rise
            #40 r[i] = tdo_i;
            tck_o = 1'b1;
            #40 tck_o = 1'b0;
        end
        // Released data line shows the inverse so stale bits cannot pass
        tdi_o = ~tdi_o;
    endtask
    task automatic logic_reset;
        tms_o = 1'b1;
        repeat (5) begin
            #40 tck_o = 1'b1;
            #40 tck_o = 1'b0;
        end
        tms_o = 1'b0;
    endtask
endmodule // bpde_host

// ---- tb/tb_bpde_top.sv ----
// Bench for the breakpoint debug entry block.
// Assumes bpde_host on the link pins and the bound checker.
`timescale 1ns/1ps
`include "bpde_defines.vh"
module tb_bpde_top;
    logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, prefix_register = 1'b0, exd = 1'b0, irq = 1'b1;
    logic [15:0] dma = 16'h0000, dsd = 16'h0000, ret = 16'h0ABC, pushd, ipv, last_push;
    logic [8:0] dsr = 9'h000;
    logic [9:0] rx;
    logic tck, tms, tdi, tdo, fb, push, ipl, gie, halt, dbg, ten, grant;
    int num_errors = 0, total_checks = 0, pushes = 0;
    bpde_top uut (.ref_clk_i(clk), .resetn_i(rst_n), .ce_i(1'b1), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo), .instr_done_i(done), .instr_pfx_i(prefix_register), .dmem_valid_i(1'b1),
        .dmem_addr_i(dma), .dst_valid_i(1'b1), .dst_reg_i(dsr), .dst_data_i(dsd),
        .return_addr_i(ret), .irq_req_i(irq), .exit_debug_i(exd), .fetch_block_o(fb),
        .push_o(push), .push_data_o(pushd), .ip_load_o(ipl), .ip_value_o(ipv),
        .gie_clear_o(gie), .cpu_halt_o(halt), .debug_mode_o(dbg), .timer_clk_en_o(ten),
        .irq_grant_o(grant));
    bpde_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (push === 1'b1) begin
            pushes++;
            last_push <= pushd;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic link(input logic [2:0] cmd, input logic [6:0] pl);
        host.xfer({cmd, pl}, rx);
    endtask
    // Stage bytes ride in the payload, so values keep bits 15 and 7 clear
    task automatic wr(input logic [2:0] cmd, input logic [6:0] pl, input logic [15:0] v);
        link(3'h0, v[14:8]);
        link(3'h0, v[6:0]);
        link(cmd, pl);
    endtask
    task automatic rd(input logic [2:0] cmd, input logic [6:0] pl, input logic [7:0] exp);
        link(cmd, pl);
        link(3'h0, 7'h00);
        chk("read byte", {8'h00, exp}, {8'h00, rx[7:0]});
    endtask
    task automatic try(input logic p, input logic [15:0] a, input logic [8:0] r,
            input logic [15:0] d, input logic e);
        @(negedge clk);
        done = 1'b1;
        prefix_register = p;
        dma = a;
        dsr = r;
        dsd = d;
        @(negedge clk);
        done = 1'b0;
        prefix_register = 1'b0;
        dma = 16'h0000;
        dsr = 9'h000;
        dsd = 16'h0000;
        // A pending break is only taken at the next instruction boundary
        @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        repeat (8) @(negedge clk);
        chk("fetch block", {15'h0, e}, {15'h0, fb});
    endtask
    task automatic leave;
        exd = 1'b1;
        @(negedge clk);
        exd = 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(3'h2, 7'h0D, 8'hFF);
        rd(3'h2, 7'h08, 8'hFF);
        rd(3'h7, 7'h00, 8'h00);
        chk("status", 16'h0, {14'h0, rx[9:8]});
        $display("reset test done");
    endtask
    task automatic t_addr;
        wr(3'h1, 7'h05, 16'h1234);
        wr(3'h3, 7'h00, 16'h0000);
        try(1'b0, 16'h1234, 9'h000, 16'h0000, 1'b0);
        chk("grant", 16'h1, {15'h0, grant});
        wr(3'h3, 7'h00, 16'h0001);
        try(1'b0, 16'h1233, 9'h000, 16'h0000, 1'b0);
        try(1'b0, 16'h1234, 9'h000, 16'h0000, 1'b1);
        chk("pushed", ret, last_push);
        chk("timer clock", 16'h0, {15'h0, ten});
        chk("grant", 16'h0, {15'h0, grant});
        // Status is latched at the end of a word, so it shows one word later
        link(3'h0, 7'h00);
        link(3'h6, 7'h00);
        chk("status", {14'h0, `BPDE_ST_DEBUG_IDLE}, {14'h0, rx[9:8]});
        try(1'b0, 16'h1234, 9'h000, 16'h0000, 1'b1);
        chk("push count", 16'h1, pushes[15:0]);
        leave();
        $display("address test done");
    endtask
    task automatic t_reg;
        wr(3'h1, 7'h05, 16'h7F37);
        wr(3'h4, 7'h00, 16'h0055);
        wr(3'h5, 7'h00, 16'h007F);
        wr(3'h3, 7'h00, 16'h0003);
        try(1'b0, 16'h7F37, 9'h000, 16'h0055, 1'b0);
        try(1'b0, 16'h0000, 9'h136, 16'h0055, 1'b0);
        try(1'b0, 16'h0000, 9'h137, 16'h0056, 1'b0);
        try(1'b0, 16'h0000, 9'h137, 16'h1255, 1'b1);
        leave();
        wr(3'h5, 7'h00, 16'h0000);
        try(1'b0, 16'h0000, 9'h137, 16'h7777, 1'b1);
        leave();
        $display("register test done");
    endtask
    task automatic t_pfx;
        wr(3'h1, 7'h05, 16'h1234);
        wr(3'h3, 7'h00, 16'h0001);
        try(1'b1, 16'h1234, 9'h000, 16'h0000, 1'b0);
        try(1'b0, 16'h0000, 9'h000, 16'h0000, 1'b1);
        leave();
        $display("prefix test done");
    endtask
    task automatic t_dbg;
        link(3'h6, 7'h00);
        try(1'b0, 16'h0000, 9'h000, 16'h0000, 1'b1);
        for (int i = 0; i < 200 && dbg !== 1'b1; i++) @(negedge clk);
        chk("debug mode", 16'h1, {15'h0, dbg});
        leave();
        host.logic_reset();
        rd(3'h2, 7'h05, 8'hFF);
        rd(3'h7, 7'h00, 8'h00);
        $display("command test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_addr();
        t_reg();
        t_pfx();
        t_dbg();
        report_and_stop();
    end
    // About 50 link words of 100 cycles each, with ample margin
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule // tb_bpde_top
